/* csc_params.svh */
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH
// register port geometry
`define CSC_ADDR_W 12
`define CSC_DATA_W 8
// register offsets
`define CSC_CAL_SYNC_OFF 12'ha02
`define CSC_RESET_FN_OFF 12'ha03
`define CSC_CLR_SYS_OFF 12'ha04
`define CSC_CLR_SWN_OFF 12'ha05
`define CSC_CLR_DPLL_OFF 12'ha06
`define CSC_STATUS_OFF 12'ha7f
// calibrate and sync control fields
`define CSC_CAL_BIT 0
`define CSC_SYNC_BIT 1
// reset function strobe fields
`define CSC_RF_WDOG 0
`define CSC_RF_ALL_IRQ 1
`define CSC_RF_HIST 2
`define CSC_RF_AUTOSYNC 3
`define CSC_RF_PHACC 4
`define CSC_RF_DECIM 5
`define CSC_RF_LOOP 6
// implemented bits of each strobe register
`define CSC_RF_MASK 8'h7f
`define CSC_CLR_SYS_MASK 8'h33
`define CSC_CLR_SWN_MASK 8'h0f
`define CSC_CLR_DPLL_MASK 8'hff
// reset values
`define CSC_BYTE_RST 8'h00
// timing
`define CSC_CLK_PERIOD_NS 8
`define CSC_CAL_STEP_NS 1000
`define CSC_CAL_WAIT_US 2000
`define CSC_WD_PERIOD_MS 10
`endif

/* csc_pkg.sv */
package csc_pkg;
    // calibration sequencer states
    typedef enum logic [2:0] {
        CAL_IDLE,
        CAL_BAND,
        CAL_AMPL,
        CAL_SETTLE,
        CAL_DONE
    } csc_cal_state_type;
    // register decode result
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_CAL_SYNC,
        SEL_RESET_FN,
        SEL_CLR,
        SEL_STATUS
    } csc_sel_type;
endpackage : csc_pkg

/* csc_regs.sv */
// What this block does
// - sync bit high stalls distribution outputs
// - distribution sync fires on sync bit falling
// - committed calibrate rise starts enabled PLL calibration
// - calibration picks band and amplitude itself
// - system clock stalls for whole calibration
// - loop filter clear bit clears loop filter
// - decimation clear bit clears decimation filter
// - accumulator clear bit zeroes phase accumulator
// - auto-sync reset bit resets auto-sync logic
// - history reset bit resets tuning word history
// - clear-all bit clears every interrupt monitor bit
// - watchdog strobe restarts count without timeout
// - reset function bits clear themselves
// - clearing bit resets matching monitor bit
// - interrupt clearing bits are one-shot strobes
// - system clock clearing bits 5,4,1,0 only
// - second clearing register bits 3 to 0
// - digital PLL clearing bit 7 is switching
// - digital PLL bits 6 to 0 clear loop events
`include "csc_params.svh"

module csc_regs #(
    parameter int BAND_W = 3,
    parameter int AMPL_W = 3,
    parameter int unsigned CAL_WAIT_CYCLES =
        `CSC_CAL_WAIT_US * 1000 / `CSC_CLK_PERIOD_NS,
    parameter int unsigned WD_CYCLES =
        `CSC_WD_PERIOD_MS * 1000000 / `CSC_CLK_PERIOD_NS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic [`CSC_ADDR_W-1:0] reg_addr,
    input wire logic [`CSC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`CSC_DATA_W-1:0] reg_rdata_q,
    // register update commit strobe
    input wire logic reg_update,
    // system clock PLL interface
    input wire logic pll_enable,
    input wire logic band_ok,
    input wire logic ampl_ok,
    output logic [BAND_W-1:0] cal_band_q,
    output logic [AMPL_W-1:0] cal_ampl_q,
    output logic system_pll_clock_stall_q,
    output logic cal_started_q,
    output logic cal_complete_q,
    // clock distribution
    output logic dist_stall_q,
    output logic dist_sync_q,
    // reset strobes into the datapath
    output logic loop_filter_clear_q,
    output logic decim_clear_q,
    output logic phase_acc_clear_q,
    output logic auto_sync_reset_q,
    output logic history_reset_q,
    // interrupt monitor clearing
    output logic irq_clear_all_q,
    output logic [`CSC_DATA_W-1:0] irq_clr_sys_q,
    output logic [`CSC_DATA_W-1:0] irq_clr_swn_q,
    output logic [`CSC_DATA_W-1:0] irq_clr_dpll_q,
    // watchdog
    input wire logic wd_enable,
    output logic wd_timeout_q
);
    import csc_pkg::*;

    // dwell per calibration step, least time so round up
    localparam int unsigned STEP_CYCLES =
        (`CSC_CAL_STEP_NS + `CSC_CLK_PERIOD_NS - 1) / `CSC_CLK_PERIOD_NS;
    localparam int CNT_W = 32;

    // refuse widths the sequencer cannot serve
    if (BAND_W < 1 || BAND_W > 8 || AMPL_W < 1 || AMPL_W > 8) begin : g_chk_w
        $error("csc_regs: band and amplitude widths must be 1 to 8");
    end
    if (CAL_WAIT_CYCLES < 1 || WD_CYCLES < 2) begin : g_chk_t
        $error("csc_regs: timing counts too small");
    end

    ////////////////////////////////////////////////////////////////////////
    // address decode

    // decode shared by the write and read paths
    function automatic csc_sel_type decode(
        input logic [`CSC_ADDR_W-1:0] a
    );
        csc_sel_type s;
        s = SEL_NONE;
        case (a)
            `CSC_CAL_SYNC_OFF: s = SEL_CAL_SYNC;
            `CSC_RESET_FN_OFF: s = SEL_RESET_FN;
            `CSC_CLR_SYS_OFF,
            `CSC_CLR_SWN_OFF,
            `CSC_CLR_DPLL_OFF: s = SEL_CLR;
            `CSC_STATUS_OFF: s = SEL_STATUS;
            default: s = SEL_NONE;
        endcase
        return s;
    endfunction : decode

    csc_sel_type wsel; // target of this cycle's write
    csc_sel_type rsel; // target of this cycle's read
    assign wsel = reg_wr ? decode(reg_addr) : SEL_NONE;
    assign rsel = reg_rd ? decode(reg_addr) : SEL_NONE;

    ////////////////////////////////////////////////////////////////////////
    // calibrate and sync control

    logic cal_buf_q; // written calibrate bit, not yet committed
    logic cal_act_q; // committed calibrate bit
    logic sync_q; // distribution sync control bit
    logic cal_go; // start request for the sequencer
    csc_cal_state_type cal_st_q; // sequencer state

    // software must drop the bit to retrigger
    // writable bits of the control register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cal_buf_q <= 1'b0;
            sync_q <= 1'b0;
        end else if (wsel == SEL_CAL_SYNC) begin
            cal_buf_q <= reg_wdata[`CSC_CAL_BIT];
            sync_q <= reg_wdata[`CSC_SYNC_BIT];
        end
    end

    // commit on the update strobe; data written in the same cycle waits for the next strobe
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cal_act_q <= 1'b0;
        end else if (reg_update) begin
            cal_act_q <= cal_buf_q;
        end
    end

    // committed rise with PLL enabled
    // a start arriving mid-calibration is dropped, bit stays set
    assign cal_go = reg_update && cal_buf_q && !cal_act_q && pll_enable
        && cal_st_q == CAL_IDLE;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            dist_stall_q <= 1'b0;
        end else begin
            dist_stall_q <= sync_q;
        end
    end

    // sync fires on the falling edge only
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            dist_sync_q <= 1'b0;
        end else begin
            dist_sync_q <= dist_stall_q && !sync_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // calibration sequencer

    logic [CNT_W-1:0] cal_cnt_q; // dwell counter within a step
    logic step_end; // dwell of current step elapsed
    logic wait_end; // final settle elapsed
    assign step_end = cal_cnt_q == CNT_W'(STEP_CYCLES - 1);
    assign wait_end = cal_cnt_q == CNT_W'(CAL_WAIT_CYCLES - 1);

    // band search then amplitude search
    // walks bands upward, then raises amplitude until the analog
    // comparator agrees; the last code is kept if none passes
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cal_st_q <= CAL_IDLE;
            cal_cnt_q <= '0;
            cal_band_q <= '0;
            cal_ampl_q <= '0;
        end else begin
            case (cal_st_q)
                CAL_IDLE: begin
                    cal_cnt_q <= '0;
                    if (cal_go) begin
                        cal_st_q <= CAL_BAND;
                        cal_band_q <= '0;
                        cal_ampl_q <= '0;
                    end
                end
                CAL_BAND: begin
                    cal_cnt_q <= step_end ? '0 : cal_cnt_q + 1'b1;
                    if (step_end) begin
                        if (band_ok || &cal_band_q) begin
                            cal_st_q <= CAL_AMPL;
                        end else begin
                            cal_band_q <= cal_band_q + 1'b1;
                        end
                    end
                end
                CAL_AMPL: begin
                    cal_cnt_q <= step_end ? '0 : cal_cnt_q + 1'b1;
                    if (step_end) begin
                        if (ampl_ok || &cal_ampl_q) begin
                            cal_st_q <= CAL_SETTLE;
                        end else begin
                            cal_ampl_q <= cal_ampl_q + 1'b1;
                        end
                    end
                end
                CAL_SETTLE: begin
                    // loop lock time dominates, a few milliseconds
                    cal_cnt_q <= wait_end ? '0 : cal_cnt_q + 1'b1;
                    if (wait_end) begin
                        cal_st_q <= CAL_DONE;
                    end
                end
                CAL_DONE: begin
                    cal_cnt_q <= '0;
                    cal_st_q <= CAL_IDLE;
                end
                default: begin
                    cal_cnt_q <= '0;
                    cal_st_q <= CAL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            system_pll_clock_stall_q <= 1'b0;
        end else begin
            system_pll_clock_stall_q <= cal_go || (cal_st_q != CAL_IDLE
                && cal_st_q != CAL_DONE);
        end
    end

    // start and completion events for the monitor
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cal_started_q <= 1'b0;
            cal_complete_q <= 1'b0;
        end else begin
            cal_started_q <= cal_go;
            cal_complete_q <= cal_st_q == CAL_DONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset function strobes

    logic [`CSC_DATA_W-1:0] rf_d; // strobes for this write
    assign rf_d = (wsel == SEL_RESET_FN)
        ? (reg_wdata & `CSC_RF_MASK) : `CSC_BYTE_RST;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            loop_filter_clear_q <= 1'b0;
            decim_clear_q <= 1'b0;
            phase_acc_clear_q <= 1'b0;
            auto_sync_reset_q <= 1'b0;
            history_reset_q <= 1'b0;
            irq_clear_all_q <= 1'b0;
        end else begin
            loop_filter_clear_q <= rf_d[`CSC_RF_LOOP];
            decim_clear_q <= rf_d[`CSC_RF_DECIM];
            phase_acc_clear_q <= rf_d[`CSC_RF_PHACC];
            auto_sync_reset_q <= rf_d[`CSC_RF_AUTOSYNC];
            history_reset_q <= rf_d[`CSC_RF_HIST];
            irq_clear_all_q <= rf_d[`CSC_RF_ALL_IRQ];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog

    logic [CNT_W-1:0] wd_cnt_q; // elapsed cycles of this timing cycle
    logic wd_last; // last cycle of the period

    assign wd_last = wd_cnt_q == CNT_W'(WD_CYCLES - 1);

    // kick restarts at zero, no timeout
    // a kick in the expiring cycle wins, so no event is raised
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wd_cnt_q <= '0;
            wd_timeout_q <= 1'b0;
        end else if (!wd_enable || rf_d[`CSC_RF_WDOG]) begin
            wd_cnt_q <= '0;
            wd_timeout_q <= 1'b0;
        end else begin
            wd_cnt_q <= wd_last ? '0 : wd_cnt_q + 1'b1;
            wd_timeout_q <= wd_last;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt clearing strobes

    logic [`CSC_DATA_W-1:0] clr_mask [3]; // implemented bits per register
    logic [`CSC_ADDR_W-1:0] clr_addr [3]; // offset per register
    logic [`CSC_DATA_W-1:0] clr_q [3]; // strobe outputs
    assign clr_mask[0] = `CSC_CLR_SYS_MASK;
    assign clr_mask[1] = `CSC_CLR_SWN_MASK;
    assign clr_mask[2] = `CSC_CLR_DPLL_MASK;
    assign clr_addr[0] = `CSC_CLR_SYS_OFF;
    assign clr_addr[1] = `CSC_CLR_SWN_OFF;
    assign clr_addr[2] = `CSC_CLR_DPLL_OFF;

    for (genvar g = 0; g < 3; g++) begin : g_clr
        // one bit clears its monitor bit
        always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
                clr_q[g] <= `CSC_BYTE_RST;
            end else if (rf_d[`CSC_RF_ALL_IRQ]) begin
                clr_q[g] <= clr_mask[g];
            end else if (wsel == SEL_CLR && reg_addr == clr_addr[g]) begin
                clr_q[g] <= reg_wdata & clr_mask[g];
            end else begin
                clr_q[g] <= `CSC_BYTE_RST;
            end
        end
    end

    assign irq_clr_sys_q = clr_q[0];
    // sync, watchdog, memory bits 3 to 0
    assign irq_clr_swn_q = clr_q[1];
    // bits 6 to 0 loop events
    assign irq_clr_dpll_q = clr_q[2];

    ////////////////////////////////////////////////////////////////////////
    // read path

    // strobe registers read zero
    // unmapped and write-only offsets answer zero
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_q <= `CSC_BYTE_RST;
        end else begin
            case (rsel)
                SEL_CAL_SYNC: reg_rdata_q <= {6'h00, sync_q, cal_buf_q};
                SEL_STATUS: reg_rdata_q <= {4'h0, wd_enable,
                    dist_stall_q, cal_act_q, system_pll_clock_stall_q};
                default: reg_rdata_q <= `CSC_BYTE_RST;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    sequence s_cal_start;
        reg_update && cal_buf_q && !cal_act_q && pll_enable
            && cal_st_q == CAL_IDLE;
    endsequence

    sequence s_cal_begin;
        system_pll_clock_stall_q && cal_started_q;
    endsequence

    dist_stall_follow_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        sync_q |=> dist_stall_q)
        else $error("distribution not stalled while sync set");

    dist_sync_fall_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        dist_sync_q |-> $past(dist_stall_q) && !dist_stall_q)
        else $error("distribution sync without falling bit");

    cal_start_seq_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_cal_start |=> s_cal_begin)
        else $error("calibration did not start");

    cal_stall_hold_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (cal_st_q == CAL_BAND || cal_st_q == CAL_AMPL) |=> system_pll_clock_stall_q)
        else $error("system clock running during calibration");

    cal_band_walk_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (cal_st_q == CAL_BAND && step_end && !band_ok && !(&cal_band_q))
            |=> cal_band_q == $past(cal_band_q) + 1'b1)
        else $error("band search did not advance");

    rf_strobe_pulse_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (reg_wr && reg_addr == `CSC_RESET_FN_OFF
            && reg_wdata[`CSC_RF_LOOP]) ##1 !reg_wr |=> !loop_filter_clear_q)
        else $error("loop filter clear did not self clear");

    clr_all_fan_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        irq_clear_all_q |-> irq_clr_sys_q == `CSC_CLR_SYS_MASK
            && irq_clr_swn_q == `CSC_CLR_SWN_MASK
            && irq_clr_dpll_q == `CSC_CLR_DPLL_MASK)
        else $error("clear all did not reach every clearing bit");

    clr_unused_zero_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (irq_clr_sys_q & ~`CSC_CLR_SYS_MASK) == 8'h00
            && (irq_clr_swn_q & ~`CSC_CLR_SWN_MASK) == 8'h00)
        else $error("unused clearing bit fired");

    wd_kick_quiet_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (reg_wr && reg_addr == `CSC_RESET_FN_OFF
            && reg_wdata[`CSC_RF_WDOG]) |=> wd_cnt_q == '0 && !wd_timeout_q)
        else $error("watchdog kick did not restart quietly");

    strobe_read_zero_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (reg_rd && decode(reg_addr) inside {SEL_RESET_FN, SEL_CLR})
            |=> reg_rdata_q == 8'h00)
        else $error("strobe register read nonzero");

endmodule : csc_regs

/* csc_regs_tb.sv */
`include "csc_params.svh"

module csc_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////
    // shortened counts so the run stays brief
    localparam int unsigned CAL_WAIT = 20;
    localparam int unsigned WD_LEN = 50;
    // clock and reset
    logic mclk;
    logic sys_rst;
    // register port
    logic [`CSC_ADDR_W-1:0] reg_addr;
    logic [`CSC_DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [`CSC_DATA_W-1:0] reg_rdata_q;
    logic reg_update;
    // system pll side
    logic pll_enable;
    logic band_ok;
    logic ampl_ok;
    logic [2:0] cal_band_q;
    logic [2:0] cal_ampl_q;
    logic system_pll_clock_stall_q;
    logic cal_started_q;
    logic cal_complete_q;
    // distribution, strobes, watchdog
    logic dist_stall_q;
    logic dist_sync_q;
    logic loop_filter_clear_q;
    logic decim_clear_q;
    logic phase_acc_clear_q;
    logic auto_sync_reset_q;
    logic history_reset_q;
    logic irq_clear_all_q;
    logic [`CSC_DATA_W-1:0] irq_clr_sys_q;
    logic [`CSC_DATA_W-1:0] irq_clr_swn_q;
    logic [`CSC_DATA_W-1:0] irq_clr_dpll_q;
    logic wd_enable;
    logic wd_timeout_q;
    // bookkeeping
    int n_fail;
    int compares;
    logic [7:0] rd_val;

    csc_regs #(
        .CAL_WAIT_CYCLES(CAL_WAIT),
        .WD_CYCLES(WD_LEN)
    ) csc_regs_inst (
        .mclk(mclk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .reg_update(reg_update), .pll_enable(pll_enable),
        .band_ok(band_ok), .ampl_ok(ampl_ok),
        .cal_band_q(cal_band_q), .cal_ampl_q(cal_ampl_q),
        .system_pll_clock_stall_q(system_pll_clock_stall_q), .cal_started_q(cal_started_q),
        .cal_complete_q(cal_complete_q),
        .dist_stall_q(dist_stall_q), .dist_sync_q(dist_sync_q),
        .loop_filter_clear_q(loop_filter_clear_q),
        .decim_clear_q(decim_clear_q),
        .phase_acc_clear_q(phase_acc_clear_q),
        .auto_sync_reset_q(auto_sync_reset_q),
        .history_reset_q(history_reset_q),
        .irq_clear_all_q(irq_clear_all_q),
        .irq_clr_sys_q(irq_clr_sys_q), .irq_clr_swn_q(irq_clr_swn_q),
        .irq_clr_dpll_q(irq_clr_dpll_q),
        .wd_enable(wd_enable), .wd_timeout_q(wd_timeout_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // free running clock, 8 ns period
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // datapath strobes packed at their reset-function bit positions
    function automatic logic [7:0] strobes();
        return {1'b0, loop_filter_clear_q, decim_clear_q, phase_acc_clear_q,
                auto_sync_reset_q, history_reset_q, irq_clear_all_q, 1'b0};
    endfunction : strobes

    // one comparison, reported at once on mismatch
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask : chk

    task automatic print_verdict();
        if (n_fail == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    // one-cycle write; returns in the cycle where its effects show
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    // one-cycle read; data taken in the only cycle it stands
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_q;
    endtask : rd

    // commit strobe; returns in the cycle a start would show
    task automatic upd();
        @(posedge mclk);
        reg_update <= 1'b1;
        @(posedge mclk);
        reg_update <= 1'b0;
        #1;
    endtask : upd

    task automatic step();
        @(posedge mclk);
        #1;
    endtask : step

    ////////////////////////////////////////////////////////////////////////
    // reset-function strobes fire once and fall back by themselves
    task automatic t_strobes();
        for (int b = 1; b < 7; b++) begin
            wr(`CSC_RESET_FN_OFF, 8'h01 << b);
            chk(strobes(), 8'h01 << b);
            if (b == 1) begin
                chk(irq_clr_sys_q, 8'h33);
                chk(irq_clr_swn_q, 8'h0f);
                chk(irq_clr_dpll_q, 8'hff);
            end
            step();
            chk(strobes(), 8'h00);
        end
        // unused bit 7 does nothing; register reads back zero
        wr(`CSC_RESET_FN_OFF, 8'h80);
        chk(strobes(), 8'h00);
        rd(`CSC_RESET_FN_OFF, rd_val);
        chk(rd_val, 8'h00);
    endtask : t_strobes

    // interrupt clearing registers, masked to their used bits
    task automatic t_irq_clear();
        wr(`CSC_CLR_SYS_OFF, 8'hff);
        chk(irq_clr_sys_q, 8'h33);
        step();
        chk(irq_clr_sys_q, 8'h00);
        wr(`CSC_CLR_SWN_OFF, 8'hff);
        chk(irq_clr_swn_q, 8'h0f);
        wr(`CSC_CLR_DPLL_OFF, 8'h80);
        chk(irq_clr_dpll_q, 8'h80);
        wr(`CSC_CLR_DPLL_OFF, 8'h7f);
        chk(irq_clr_dpll_q, 8'h7f);
        step();
        chk(irq_clr_dpll_q, 8'h00);
        wr(`CSC_CLR_SWN_OFF, 8'h00);
        chk(irq_clr_swn_q, 8'h00);
        rd(`CSC_CLR_DPLL_OFF, rd_val);
        chk(rd_val, 8'h00);
        rd(12'h123, rd_val);
        chk(rd_val, 8'h00);
    endtask : t_irq_clear

    // distribution stalls while the bit is one, syncs on its fall
    task automatic t_dist_sync();
        wr(`CSC_CAL_SYNC_OFF, 8'h02);
        chk({7'h00, dist_sync_q}, 8'h00);
        step();
        chk({7'h00, dist_stall_q}, 8'h01);
        rd(`CSC_CAL_SYNC_OFF, rd_val);
        chk(rd_val, 8'h02);
        chk({7'h00, dist_stall_q}, 8'h01);
        wr(`CSC_CAL_SYNC_OFF, 8'h00);
        // stall still high here; the sync follows one cycle later
        chk({6'h00, dist_stall_q, dist_sync_q}, 8'h02);
        step();
        chk({6'h00, dist_stall_q, dist_sync_q}, 8'h01);
        step();
        chk({7'h00, dist_sync_q}, 8'h00);
    endtask : t_dist_sync

    // refused start, rewrite sequence, full calibration, stale update
    task automatic t_calibrate();
        int n;
        @(posedge mclk);
        pll_enable <= 1'b0;
        band_ok <= 1'b0;
        wr(`CSC_CAL_SYNC_OFF, 8'h01);
        upd();
        chk({6'h00, cal_started_q, system_pll_clock_stall_q}, 8'h00);
        @(posedge mclk);
        pll_enable <= 1'b1;
        wr(`CSC_CAL_SYNC_OFF, 8'h00);
        upd();
        wr(`CSC_CAL_SYNC_OFF, 8'h01);
        // a rise alone starts nothing until it is committed
        chk({6'h00, cal_started_q, system_pll_clock_stall_q}, 8'h00);
        upd();
        chk({6'h00, cal_started_q, system_pll_clock_stall_q}, 8'h03);
        // status: committed bit and stall both visible
        rd(`CSC_STATUS_OFF, rd_val);
        chk(rd_val, 8'h03);
        n = 0;
        while (cal_complete_q !== 1'b1 && n < 3000) begin
            step();
            chk({7'h00, system_pll_clock_stall_q}, {7'h00, ~cal_complete_q});
            n++;
        end
        if (n >= 3000) begin
            n_fail++;
            print_verdict();
        end
        // no band ever fits, so the upward walk ends on the top band
        chk({5'h00, cal_band_q}, 8'h07);
        // amplitude fits at once, so the first code is kept
        chk({5'h00, cal_ampl_q}, 8'h00);
        upd();
        chk({6'h00, cal_started_q, system_pll_clock_stall_q}, 8'h00);
    endtask : t_calibrate

    // kicks inside the period hold off the timeout; then it fires
    task automatic t_watchdog();
        int n;
        @(posedge mclk);
        wd_enable <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            repeat (WD_LEN - 20) begin
                step();
                chk({7'h00, wd_timeout_q}, 8'h00);
            end
            wr(`CSC_RESET_FN_OFF, 8'h01);
        end
        n = 0;
        while (wd_timeout_q !== 1'b1 && n < 2 * WD_LEN) begin
            step();
            n++;
        end
        chk(8'(n), 8'(WD_LEN));
        // after expiry a new timing cycle starts, no second event
        step();
        chk({7'h00, wd_timeout_q}, 8'h00);
    endtask : t_watchdog

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        n_fail = 0;
        compares = 0;
        sys_rst = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_update = 1'b0;
        pll_enable = 1'b1;
        band_ok = 1'b1;
        ampl_ok = 1'b1;
        wd_enable = 1'b0;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(`CSC_CAL_SYNC_OFF, rd_val);
        chk(rd_val, 8'h00);
        t_strobes();
        t_irq_clear();
        t_dist_sync();
        t_calibrate();
        t_watchdog();
        print_verdict();
    end
endmodule : csc_regs_tb
